// [hdl/ddr_lane_pkg.sv]
package ddr_lane_pkg;

   // ==========================================================
   // Phase slots: each system clock cycle is cut into quarters
   localparam int SLOTS              = 4;
   localparam int SLOT_DEG           = 360 / SLOTS;
   localparam int WR_DQ_PHASE_DEG    = -90;
   localparam int WR_DQ_LEAD_SLOTS   = -WR_DQ_PHASE_DEG / SLOT_DEG;
   localparam int RD_DQS_DELAY_DEG   = 90;
   localparam int RD_DQS_DELAY_SLOTS = RD_DQS_DELAY_DEG / SLOT_DEG;

   // ==========================================================
   // Strobe shape and pin idle values
   localparam logic [SLOTS-1:0] WR_DQS_PATTERN = 4'h3;
   localparam logic             DM_N_IDLE      = 1'h1;
   localparam logic             OE_N_RELEASED  = 1'h1;

   // ==========================================================
   // Lane organisation
   localparam int BYTE_W      = 8;
   localparam int ECC_BITS    = 8;
   localparam int DATA_W_DEF  = 64;
   localparam int DEV_W_DEF   = 8;

   // ==========================================================
   // Mask line usage
   typedef enum logic [1:0] {
      MASK_NONE,
      MASK_DDR3_DM,
      MASK_DDR4_DM,
      MASK_DDR4_DBI
   } mask_mode_t;

endpackage

// [hdl/lane_cap_if.sv]
`timescale 1ns/1ns
interface lane_cap_if #(parameter int LW = 10) ();
   import ddr_lane_pkg::*;

   logic                     rd_en;
   logic [SLOTS-1:0]         dqs_slots;
   logic [SLOTS-1:0][LW-1:0] dq_slots;
   logic [LW-1:0]            rise_beat;
   logic [LW-1:0]            fall_beat;
   logic                     beat_valid;

   modport core (output rd_en, dqs_slots, dq_slots, input rise_beat, fall_beat, beat_valid);
   modport lane (input rd_en, dqs_slots, dq_slots, output rise_beat, fall_beat, beat_valid);
endinterface

// [hdl/write_byte_code.sv]
`timescale 1ns/1ns
module write_byte_code
   import ddr_lane_pkg::*;
#(
   parameter int BW = BYTE_W
)
(
   input  wire mask_mode_t   mode,
   input  wire logic [BW-1:0] data_in,
   input  wire logic          byte_en,
   output logic      [BW-1:0] code_out,
   output logic               mask_out,
   input  wire logic [BW-1:0] rd_in,
   input  wire logic          rd_dbi_n,
   output logic      [BW-1:0] rd_out
);
   localparam int ZW = $clog2(BW + 1);

   if (BW < 2) begin : g_bad_width
      $error("write_byte_code: byte width too small");
   end

   logic [ZW-1:0] zeros;
   logic          invert;

   // Per-byte write coding and read restore
   always_comb begin
      zeros = '0;
      for (int i = 0; i < BW; i++) begin
         zeros = zeros + ZW'(!data_in[i]);
      end
      invert   = (mode == MASK_DDR4_DBI) && (zeros > ZW'(BW / 2));
      code_out = invert ? ~data_in : data_in;
      unique case (mode)
         MASK_NONE:     mask_out = DM_N_IDLE;
         MASK_DDR3_DM:  mask_out = ~byte_en;
         MASK_DDR4_DM:  mask_out = byte_en;
         MASK_DDR4_DBI: mask_out = ~invert;
      endcase
      rd_out = ((mode == MASK_DDR4_DBI) && !rd_dbi_n) ? ~rd_in : rd_in;
   end
endmodule

// [hdl/lane_capture.sv]
`timescale 1ns/1ns
module lane_capture
   import ddr_lane_pkg::*;
#(
   parameter int LW = 10
)
(
   input  wire logic clock,
   input  wire logic reset,
   lane_cap_if.lane  cap
);
   localparam int D = RD_DQS_DELAY_SLOTS;

   if (D < 1 || D >= SLOTS) begin : g_bad_delay
      $error("lane_capture: strobe delay must be 1 to 3 slots");
   end

   logic [SLOTS-1:0]   prev_dqs_r;
   logic [SLOTS-1:0]   prev_dqs_nxt;
   logic [LW-1:0]      rise_r;
   logic [LW-1:0]      rise_nxt;
   logic [LW-1:0]      fall_r;
   logic [LW-1:0]      fall_nxt;
   logic               got_rise_r;
   logic               got_rise_nxt;
   logic               valid_r;
   logic               valid_nxt;
   logic [2*SLOTS-1:0] hist;

   // Delay own strobe by D slots, capture data at delayed edges
   always_comb begin
      hist         = {cap.dqs_slots, prev_dqs_r};
      prev_dqs_nxt = cap.rd_en ? cap.dqs_slots : '0;
      rise_nxt     = rise_r;
      fall_nxt     = fall_r;
      got_rise_nxt = got_rise_r;
      valid_nxt    = 1'b0;
      if (!cap.rd_en) begin
         got_rise_nxt = 1'b0;
      end else begin
         for (int k = 0; k < SLOTS; k++) begin
            if (hist[k+SLOTS-D] && !hist[k+SLOTS-D-1]) begin
               rise_nxt     = cap.dq_slots[k];
               got_rise_nxt = 1'b1;
            end
            if (!hist[k+SLOTS-D] && hist[k+SLOTS-D-1] && got_rise_nxt) begin
               fall_nxt     = cap.dq_slots[k];
               valid_nxt    = 1'b1;
               got_rise_nxt = 1'b0;
            end
         end
      end
   end

   // Capture registers
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_dqs_r <= '0;
         rise_r     <= '0;
         fall_r     <= '0;
         got_rise_r <= 1'b0;
         valid_r    <= 1'b0;
      end else begin
         prev_dqs_r <= prev_dqs_nxt;
         rise_r     <= rise_nxt;
         fall_r     <= fall_nxt;
         got_rise_r <= got_rise_nxt;
         valid_r    <= valid_nxt;
      end
   end

   assign cap.rise_beat  = rise_r;
   assign cap.fall_beat  = fall_r;
   assign cap.beat_valid = valid_r;

   // Burst-shaped strobe yields centred beats from slots 1 and 3
   a_read_center: assert property (@(posedge clock) disable iff (reset)
      (cap.rd_en && $past(cap.rd_en) && cap.dqs_slots == 4'h3 && !$past(cap.dqs_slots[3])
       && !got_rise_r)
      |=> (valid_r && rise_r == $past(cap.dq_slots[1]) && fall_r == $past(cap.dq_slots[3])))
      else $error("read beat not captured at delayed strobe edges");
endmodule

// [hdl/ddr_data_strobe_mask_path.sv]
`timescale 1ns/1ns
// Contract
// - Reads arrive edge-aligned to strobe; writes leave data centred in strobe.
// - Write data launches ninety degrees ahead of the strobe.
// - Read strobe is delayed ninety degrees before capturing data.
// - Write strobe rises with the system clock rising edge.
// - Mask lines use the same shifted double-rate launch as data.
// - DDR3 mask low writes the byte, high suppresses it.
// - DDR4 mask line is active low, shared with inversion; one function only.
// - Inversion line low means data inverted, both directions; receiver restores.
// - Groups of four or eight lanes; sixteen-wide devices use two byte groups.
// - Every group launches with its own strobe pair and captures with its own true strobe only.
// - Optional eight check bits beside 64 data bits form one group.
// - DDR3 mask rides a spare lane of its group; DDR4 line needs none.
module ddr_data_strobe_mask_path
   import ddr_lane_pkg::*;
#(
   parameter  int DEV_WIDTH  = DEV_W_DEF,
   parameter  int DATA_WIDTH = DATA_W_DEF,
   parameter  bit ECC_EN     = 1'b1,
   localparam int GW         = (DEV_WIDTH == 4) ? 4 : BYTE_W,
   localparam int TOTAL_W    = DATA_WIDTH + (ECC_EN ? ECC_BITS : 0),
   localparam int GROUPS     = TOTAL_W / GW,
   localparam int BYTES      = TOTAL_W / BYTE_W
)
(
   input  wire logic                                clock,
   input  wire logic                                reset,
   input  wire logic                                cfg_ddr4,
   input  wire logic                                cfg_dm_en,
   input  wire logic                                cfg_dbi_en,
   output logic                                     cfg_error,
   input  wire logic                                wr_valid,
   input  wire logic [1:0][TOTAL_W-1:0]             wr_data,
   input  wire logic [1:0][BYTES-1:0]               wr_byte_en,
   input  wire logic                                rd_en,
   output logic      [1:0][TOTAL_W-1:0]             rd_data,
   output logic      [GROUPS-1:0]                   rd_valid,
   output logic      [GROUPS-1:0][SLOTS-1:0][GW:0]  dq_o,
   output logic      [GROUPS-1:0]                   dq_oe_n,
   input  wire logic [GROUPS-1:0][SLOTS-1:0][GW:0]  dq_i,
   output logic      [GROUPS-1:0][SLOTS-1:0]        dqs_o,
   output logic      [GROUPS-1:0][SLOTS-1:0]        dqs_n_o,
   output logic      [GROUPS-1:0]                   dqs_oe_n,
   input  wire logic [GROUPS-1:0][SLOTS-1:0]        dqs_i,
   output logic      [GROUPS-1:0][SLOTS-1:0]        dm_dbi_o,
   output logic      [GROUPS-1:0]                   dm_dbi_oe_n,
   input  wire logic [GROUPS-1:0][SLOTS-1:0]        dm_dbi_i
);
   localparam int LW    = GW + 2;
   localparam int SPARE = GW;
   localparam int MASKL = GW + 1;

   // ==========================================================
   // Elaboration checks
   if (DEV_WIDTH != 4 && DEV_WIDTH != 8 && DEV_WIDTH != 16) begin : g_bad_dev
      $error("device width must be 4, 8 or 16");
   end
   if (DATA_WIDTH < BYTE_W || DATA_WIDTH % BYTE_W != 0) begin : g_bad_data
      $error("data width must be whole bytes");
   end
   if (ECC_EN && GW != BYTE_W) begin : g_bad_ecc
      $error("check bits need one eight-lane group");
   end
   if (WR_DQ_LEAD_SLOTS != 1) begin : g_bad_lead
      $error("write lead must be one slot");
   end

   // ==========================================================
   // Mode selection
   mask_mode_t mode_r;
   mask_mode_t mode_nxt;
   logic       cfg_error_r;
   logic       cfg_error_nxt;

   // Only one mask line function may be live at a time
   always_comb begin
      mode_nxt = MASK_NONE;
      if (GW == BYTE_W) begin
         if (!cfg_ddr4 && cfg_dm_en) begin
            mode_nxt = MASK_DDR3_DM;
         end else if (cfg_ddr4 && cfg_dm_en && !cfg_dbi_en) begin
            mode_nxt = MASK_DDR4_DM;
         end else if (cfg_ddr4 && cfg_dbi_en && !cfg_dm_en) begin
            mode_nxt = MASK_DDR4_DBI;
         end
      end
      cfg_error_nxt = (cfg_ddr4 && cfg_dm_en && cfg_dbi_en)
                    || (!cfg_ddr4 && cfg_dbi_en)
                    || ((GW != BYTE_W) && (cfg_dm_en || cfg_dbi_en));
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mode_r      <= MASK_NONE;
         cfg_error_r <= 1'b0;
      end else begin
         mode_r      <= mode_nxt;
         cfg_error_r <= cfg_error_nxt;
      end
   end

   assign cfg_error = cfg_error_r;

   // ==========================================================
   // Per-byte coding
   logic [1:0][TOTAL_W-1:0] enc;
   logic [1:0][BYTES-1:0]   enc_mask;
   wire  [1:0][TOTAL_W-1:0] rd_raw;
   wire  [1:0][BYTES-1:0]   rd_dbi_raw;
   logic [1:0][TOTAL_W-1:0] rd_dec;
   wire  [GROUPS-1:0]       grp_valid;

   for (genvar e = 0; e < 2; e++) begin : g_beat
      for (genvar b = 0; b < BYTES; b++) begin : g_byte
         write_byte_code #(.BW(BYTE_W)) u_code (
            .mode     (mode_r),
            .data_in  (wr_data[e][b*BYTE_W +: BYTE_W]),
            .byte_en  (wr_byte_en[e][b]),
            .code_out (enc[e][b*BYTE_W +: BYTE_W]),
            .mask_out (enc_mask[e][b]),
            .rd_in    (rd_raw[e][b*BYTE_W +: BYTE_W]),
            .rd_dbi_n (rd_dbi_raw[e][b]),
            .rd_out   (rd_dec[e][b*BYTE_W +: BYTE_W])
         );
      end
   end

   // ==========================================================
   // Read capture, one lane per strobe group
   for (genvar g = 0; g < GROUPS; g++) begin : g_lane
      lane_cap_if #(.LW(LW)) cap ();

      // Own strobe, data lanes, spare lane and mask line of group g only
      assign cap.rd_en     = rd_en;
      assign cap.dqs_slots = dqs_i[g];
      for (genvar k = 0; k < SLOTS; k++) begin : g_slot
         assign cap.dq_slots[k] = {dm_dbi_i[g][k], dq_i[g][k]};
      end

      lane_capture #(.LW(LW)) u_cap (
         .clock (clock),
         .reset (reset),
         .cap   (cap)
      );

      assign grp_valid[g]           = cap.beat_valid;
      assign rd_raw[0][g*GW +: GW]  = cap.rise_beat[GW-1:0];
      assign rd_raw[1][g*GW +: GW]  = cap.fall_beat[GW-1:0];
      if (GW == BYTE_W) begin : g_dbi
         assign rd_dbi_raw[0][g] = cap.rise_beat[MASKL];
         assign rd_dbi_raw[1][g] = cap.fall_beat[MASKL];
      end
   end

   if (GW != BYTE_W) begin : g_no_dbi
      assign rd_dbi_raw = '1;
   end

   // ==========================================================
   // Read result registers
   logic [1:0][TOTAL_W-1:0] rd_data_r;
   logic [1:0][TOTAL_W-1:0] rd_data_nxt;
   logic [GROUPS-1:0]       rd_valid_r;
   logic [GROUPS-1:0]       rd_valid_nxt;

   // Each group updates its slice when its own beat pair lands
   always_comb begin
      rd_data_nxt  = rd_data_r;
      rd_valid_nxt = grp_valid;
      for (int g = 0; g < GROUPS; g++) begin
         if (grp_valid[g]) begin
            rd_data_nxt[0][g*GW +: GW] = rd_dec[0][g*GW +: GW];
            rd_data_nxt[1][g*GW +: GW] = rd_dec[1][g*GW +: GW];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rd_data_r  <= '0;
         rd_valid_r <= '0;
      end else begin
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   assign rd_data  = rd_data_r;
   assign rd_valid = rd_valid_r;

   // ==========================================================
   // Write launch
   logic [1:0][GROUPS-1:0][LW-1:0]      wbeat;
   logic [LW-1:0]                       idle_line;
   logic                                p_valid_r;
   logic                                p_valid_nxt;
   logic [1:0][GROUPS-1:0][LW-1:0]      p_beat_r;
   logic [1:0][GROUPS-1:0][LW-1:0]      p_beat_nxt;
   logic [GROUPS-1:0][SLOTS-1:0][GW:0]  dq_o_r;
   logic [GROUPS-1:0][SLOTS-1:0][GW:0]  dq_o_nxt;
   logic [GROUPS-1:0]                   dq_oe_n_r;
   logic [GROUPS-1:0]                   dq_oe_n_nxt;
   logic [GROUPS-1:0][SLOTS-1:0]        dqs_o_r;
   logic [GROUPS-1:0][SLOTS-1:0]        dqs_o_nxt;
   logic [GROUPS-1:0][SLOTS-1:0]        dqs_n_o_r;
   logic [GROUPS-1:0][SLOTS-1:0]        dqs_n_o_nxt;
   logic [GROUPS-1:0]                   dqs_oe_n_r;
   logic [GROUPS-1:0]                   dqs_oe_n_nxt;
   logic [GROUPS-1:0][SLOTS-1:0]        dm_o_r;
   logic [GROUPS-1:0][SLOTS-1:0]        dm_o_nxt;
   logic [GROUPS-1:0]                   dm_oe_n_r;
   logic [GROUPS-1:0]                   dm_oe_n_nxt;
   logic                                ddr4_line;
   logic [LW-1:0]                       line;

   // Bundle each beat per group: data, spare lane, mask line
   always_comb begin
      idle_line = {DM_N_IDLE, 1'b0, {GW{1'b0}}};
      ddr4_line = (mode_r == MASK_DDR4_DM) || (mode_r == MASK_DDR4_DBI);
      for (int e = 0; e < 2; e++) begin
         for (int g = 0; g < GROUPS; g++) begin
            wbeat[e][g][GW-1:0] = enc[e][g*GW +: GW];
            wbeat[e][g][SPARE]  = (mode_r == MASK_DDR3_DM) && enc_mask[e][g*GW/BYTE_W];
            wbeat[e][g][MASKL]  = ddr4_line ? enc_mask[e][g*GW/BYTE_W] : DM_N_IDLE;
         end
      end
   end

   // Slots 0..2 carry the held beats, slot 3 leads with the next beat0, else holds beat1
   always_comb begin
      p_valid_nxt = wr_valid;
      p_beat_nxt  = wbeat;
      line        = idle_line;
      for (int g = 0; g < GROUPS; g++) begin
         for (int k = 0; k < SLOTS; k++) begin
            if (k == SLOTS - 1) begin
               line = wr_valid  ? wbeat[0][g]    :
                      p_valid_r ? p_beat_r[1][g] : idle_line;
            end else if (k == 0) begin
               line = p_valid_r ? p_beat_r[0][g] : idle_line;
            end else begin
               line = p_valid_r ? p_beat_r[1][g] : idle_line;
            end
            dq_o_nxt[g][k] = line[GW:0];
            dm_o_nxt[g][k] = line[MASKL];
         end
         dqs_o_nxt[g]    = p_valid_r ? WR_DQS_PATTERN : '0;
         dqs_n_o_nxt[g]  = ~dqs_o_nxt[g];
         dq_oe_n_nxt[g]  = !(p_valid_r || wr_valid);
         dqs_oe_n_nxt[g] = !(p_valid_r || wr_valid);
         dm_oe_n_nxt[g]  = ddr4_line ? !(p_valid_r || wr_valid) : OE_N_RELEASED;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         p_valid_r  <= 1'b0;
         p_beat_r   <= '0;
         dq_o_r     <= '0;
         dq_oe_n_r  <= {GROUPS{OE_N_RELEASED}};
         dqs_o_r    <= '0;
         dqs_n_o_r  <= '1;
         dqs_oe_n_r <= {GROUPS{OE_N_RELEASED}};
         dm_o_r     <= '1;
         dm_oe_n_r  <= {GROUPS{OE_N_RELEASED}};
      end else begin
         p_valid_r  <= p_valid_nxt;
         p_beat_r   <= p_beat_nxt;
         dq_o_r     <= dq_o_nxt;
         dq_oe_n_r  <= dq_oe_n_nxt;
         dqs_o_r    <= dqs_o_nxt;
         dqs_n_o_r  <= dqs_n_o_nxt;
         dqs_oe_n_r <= dqs_oe_n_nxt;
         dm_o_r     <= dm_o_nxt;
         dm_oe_n_r  <= dm_oe_n_nxt;
      end
   end

   assign dq_o        = dq_o_r;
   assign dq_oe_n     = dq_oe_n_r;
   assign dqs_o       = dqs_o_r;
   assign dqs_n_o     = dqs_n_o_r;
   assign dqs_oe_n    = dqs_oe_n_r;
   assign dm_dbi_o    = dm_o_r;
   assign dm_dbi_oe_n = dm_oe_n_r;

   // ==========================================================
   // Checks on launch timing, mode exclusion, mask coding and read restore
   a_dqs_pattern: assert property (@(posedge clock) disable iff (reset)
      wr_valid |-> ##2 (dqs_o_r[0] == WR_DQS_PATTERN && dqs_n_o_r[0] == ~WR_DQS_PATTERN))
      else $error("write strobe pattern missing two cycles after request");

   a_lead_beat: assert property (@(posedge clock) disable iff (reset)
      (wr_valid && mode_r == MASK_NONE)
      |=> dq_o_r[0][SLOTS-1][GW-1:0] == $past(wr_data[0][GW-1:0]))
      else $error("first beat not launched one slot ahead");

   a_center_hold: assert property (@(posedge clock) disable iff (reset)
      (wr_valid && mode_r == MASK_NONE)
      |-> ##2 (dq_o_r[0][1] == dq_o_r[0][2]
               && dq_o_r[0][1][GW-1:0] == $past(wr_data[1][GW-1:0], 2)))
      else $error("second beat not centred on falling strobe");

   a_beat_repeat: assert property (@(posedge clock) disable iff (reset)
      wr_valid |=> ##1 (dq_o_r[0][0] == $past(dq_o_r[0][SLOTS-1])))
      else $error("first beat not held across the rising strobe");

   a_drive_window: assert property (@(posedge clock) disable iff (reset)
      wr_valid |=> (!dq_oe_n_r[0] && !dqs_oe_n_r[0]) [*2])
      else $error("data or strobe not driven during write");

   a_release_idle: assert property (@(posedge clock) disable iff (reset)
      (!wr_valid && !p_valid_r) |=> (dq_oe_n_r == '1 && dqs_oe_n_r == '1))
      else $error("pins still driven with no write");

   a_mode_excl: assert property (@(posedge clock) disable iff (reset)
      (cfg_ddr4 && cfg_dm_en && cfg_dbi_en) |=> (cfg_error_r && mode_r == MASK_NONE))
      else $error("mask and inversion enabled together");

   if (GW == BYTE_W) begin : g_mask_checks
      a_ddr3_mask: assert property (@(posedge clock) disable iff (reset)
         (wr_valid && mode_r == MASK_DDR3_DM)
         |=> (dq_o_r[0][SLOTS-1][SPARE] == !$past(wr_byte_en[0][0]) && dm_oe_n_r[0]))
         else $error("DDR3 mask wrong on spare lane");

      a_ddr4_mask: assert property (@(posedge clock) disable iff (reset)
         (wr_valid && mode_r == MASK_DDR4_DM)
         |=> (dm_o_r[0][SLOTS-1] == $past(wr_byte_en[0][0]) && !dm_oe_n_r[0]))
         else $error("DDR4 mask not active low with data timing");

      a_dbi_invert: assert property (@(posedge clock) disable iff (reset)
         (wr_valid && mode_r == MASK_DDR4_DBI && wr_data[0][BYTE_W-1:0] == 8'h00)
         |=> (!dm_o_r[0][SLOTS-1] && dq_o_r[0][SLOTS-1][BYTE_W-1:0] == 8'hff))
         else $error("all-zero byte not sent inverted");

      a_dbi_restore: assert property (@(posedge clock) disable iff (reset)
         (grp_valid[0] && mode_r == MASK_DDR4_DBI && !rd_dbi_raw[0][0])
         |=> rd_data_r[0][BYTE_W-1:0] == ~$past(rd_raw[0][BYTE_W-1:0]))
         else $error("inverted read byte not restored");
   end
endmodule

// [testbench/sdram_lane_model.sv]
`timescale 1ns/1ns
module sdram_lane_model
   import ddr_lane_pkg::*;
(
   input  wire logic                       clock,
   input  wire logic                       req,
   input  wire logic [1:0][15:0]           data,
   input  wire logic                       inv,
   output logic      [1:0][SLOTS-1:0][8:0] dq,
   output logic      [1:0][SLOTS-1:0]      dqs,
   output logic      [1:0][SLOTS-1:0]      dbi_n
);
   logic [1:0]       act_r = 2'h0;
   logic [1:0][15:0] lat_r = '0;
   logic             inv_r = 1'h0;
   logic [7:0]       b0;
   logic [7:0]       b1;

   // Group one answers a cycle after group zero, like a skewed byte lane
   always_ff @(posedge clock) begin
      act_r <= {act_r[0], req};
      if (req) begin
         lat_r <= data;
         inv_r <= inv;
      end
   end

   // Edge-aligned burst per group; released lines keep the strobe low and show the inverse of beat one
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         b0 = lat_r[0][g*8+:8] ^ {8{inv_r}};
         b1 = lat_r[1][g*8+:8] ^ {8{inv_r}};
         if (act_r[g]) begin
            dqs[g]   = 4'h3;
            dq[g]    = {{1'h0, b1}, {1'h0, b1}, {1'h0, b0}, {1'h0, b0}};
            dbi_n[g] = {4{~inv_r}};
         end else begin
            dqs[g]   = 4'h0;
            dq[g]    = {4{1'h1, ~b1}};
            dbi_n[g] = {4{inv_r}};
         end
      end
   end
endmodule

// [testbench/ddr_data_strobe_mask_path_bench.sv]
`timescale 1ns/1ns
module ddr_data_strobe_mask_path_bench;
   import ddr_lane_pkg::*;
   // ==========================================================
   // Signals and cases
   typedef struct packed {
      logic [2:0]  cfg;
      logic [15:0] d0;
      logic [15:0] d1;
      logic [3:0]  be;
      logic [40:0] exp;
   } row_t;
   logic                 clock = 1'h0, reset = 1'h1, wr_valid = 1'h0, rd_en = 1'h0;
   logic                 cfg_ddr4 = 1'h0, cfg_dm_en = 1'h0, cfg_dbi_en = 1'h0;
   logic                 req = 1'h0, inv = 1'h0, cfg_error;
   logic [1:0][15:0]     wr_data = '0, rd_data, mdata = '0;
   logic [1:0][1:0]      wr_byte_en = '0;
   logic [1:0]           rd_valid, dq_oe_n, dqs_oe_n, dm_dbi_oe_n;
   logic [1:0][3:0][8:0] dq_o, dq_i;
   logic [1:0][3:0]      dqs_o, dqs_n_o, dqs_i, dm_dbi_o, dm_dbi_i;
   int                   miscompares = 0, n_tests = 0;
   row_t                 rows [6] = '{
      '{3'h0, 16'ha55a, 16'h3cc3, 4'hf, {1'h0, 4'h0, 4'hf, 16'h3cc3, 16'ha55a}},
      '{3'h2, 16'h1234, 16'h5678, 4'h6, {1'h0, 4'h9, 4'hf, 16'h5678, 16'h1234}},
      '{3'h6, 16'h9abc, 16'hdef0, 4'h9, {1'h0, 4'h0, 4'h9, 16'hdef0, 16'h9abc}},
      '{3'h5, 16'h00f0, 16'h017f, 4'hf, {1'h0, 4'h0, 4'h3, 16'hfe7f, 16'hfff0}},
      '{3'h7, 16'ha55a, 16'h3cc3, 4'hf, {1'h1, 4'h0, 4'hf, 16'h3cc3, 16'ha55a}},
      '{3'h1, 16'ha55a, 16'h3cc3, 4'hf, {1'h1, 4'h0, 4'hf, 16'h3cc3, 16'ha55a}}};

   // Clock
   always #4 clock = ~clock;

   ddr_data_strobe_mask_path #(.DEV_WIDTH(8), .DATA_WIDTH(8), .ECC_EN(1'b1)) dut (
      .clock(clock), .reset(reset), .cfg_ddr4(cfg_ddr4), .cfg_dm_en(cfg_dm_en),
      .cfg_dbi_en(cfg_dbi_en), .cfg_error(cfg_error), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_byte_en(wr_byte_en), .rd_en(rd_en), .rd_data(rd_data),
      .rd_valid(rd_valid), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i), .dqs_o(dqs_o),
      .dqs_n_o(dqs_n_o), .dqs_oe_n(dqs_oe_n), .dqs_i(dqs_i), .dm_dbi_o(dm_dbi_o),
      .dm_dbi_oe_n(dm_dbi_oe_n), .dm_dbi_i(dm_dbi_i));

   sdram_lane_model mem (.clock(clock), .req(req), .data(mdata), .inv(inv), .dq(dq_i),
      .dqs(dqs_i), .dbi_n(dm_dbi_i));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic setcfg(input logic [2:0] c);
      @(posedge clock);
      {cfg_ddr4, cfg_dm_en, cfg_dbi_en} <= c;
      repeat (2) @(posedge clock);
   endtask

   task automatic send(input logic [15:0] d0, input logic [15:0] d1, input logic [3:0] be);
      @(posedge clock);
      wr_valid   <= 1'h1;
      wr_data    <= {d1, d0};
      wr_byte_en <= be;
   endtask

   // The edge inside takes the last request
   task automatic stop();
      @(posedge clock);
      wr_valid <= 1'h0;
   endtask

   task automatic rd(input logic [15:0] d0, input logic [15:0] d1, input logic iv);
      @(posedge clock);
      req   <= 1'h1;
      mdata <= {d1, d0};
      inv   <= iv;
      @(posedge clock);
      req <= 1'h0;
      repeat (8) begin
         @(posedge clock);
         #1;
         if (rd_valid[0] === 1'h1) break;
      end
      chk(rd_valid, 2'h1);
      @(posedge clock);
      #1;
      chk(rd_valid, 2'h2);
      chk(rd_data, {d1, d0});
   endtask

   // ==========================================================
   // Sequence
   initial begin
      repeat (20) @(posedge clock);
      #1;
      chk({dq_oe_n, dqs_oe_n, dm_dbi_oe_n, dqs_n_o, dm_dbi_o, rd_valid, cfg_error},
          {6'h3f, 8'hff, 8'hff, 2'h0, 1'h0});
      @(posedge clock);
      reset <= 1'h0;
      foreach (rows[i]) begin
         setcfg(rows[i].cfg);
         send(rows[i].d0, rows[i].d1, rows[i].be);
         stop();
         @(posedge clock);
         #1;
         chk({cfg_error, dq_o[1][1][8], dq_o[1][0][8], dq_o[0][1][8], dq_o[0][0][8],
              dm_dbi_o[1][1:0], dm_dbi_o[0][1:0], dq_o[1][1][7:0], dq_o[0][1][7:0],
              dq_o[1][0][7:0], dq_o[0][0][7:0]}, rows[i].exp);
      end
      // Back-to-back writes keep the slots continuous
      setcfg(3'h0);
      send(16'h1122, 16'h3344, 4'hf);
      send(16'h5566, 16'h7788, 4'hf);
      #1;
      chk({dq_oe_n, dqs_oe_n, dqs_o, dq_o[1][3][7:0], dq_o[0][3][7:0]},
          {4'h0, 8'h00, 16'h1122});
      stop();
      #1;
      chk({dqs_o, dqs_n_o, dq_o[1][3][7:0], dq_o[0][3][7:0], dq_o[1][0][7:0],
           dq_o[0][0][7:0]}, {16'h33cc, 16'h5566, 16'h1122});
      repeat (2) @(posedge clock);
      #1;
      chk({dq_oe_n, dqs_oe_n, dqs_o}, {4'hf, 8'h00});
      @(posedge clock);
      rd_en <= 1'h1;
      rd(16'hc3a5, 16'h5a3c, 1'h0);
      setcfg(3'h5);
      rd(16'h0f0f, 16'h8001, 1'h1);
      end_of_test();
   end

   // Watchdog
   initial begin
      repeat (2000) @(posedge clock);
      miscompares++;
      end_of_test();
   end
endmodule
